// ==== include/cdt_pkg.sv ====
package cdt_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the APB bus.
    localparam logic [7:0] CDT_OFS_CTRL     = 8'h00;  // Aux timer control.
    localparam logic [7:0] CDT_OFS_HIGH     = 8'h04;  // Count high byte port.
    localparam logic [7:0] CDT_OFS_LOW      = 8'h08;  // Count low byte port.
    localparam logic [7:0] CDT_OFS_FLAGS    = 8'h0C;  // Condition flags.
    localparam logic [7:0] CDT_OFS_IRQ_STAT = 8'h10;  // Sticky interrupt status.
    localparam logic [7:0] CDT_OFS_IRQ_MASK = 8'h14;  // Interrupt mask.

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned CDT_BIT_RUN     = 7;  // Run enable in the control register.
    localparam int unsigned CDT_BIT_LOAD    = 6;  // Load strobe in the control register.
    localparam int unsigned CDT_BIT_RATE    = 5;  // Rate select in the control register.
    localparam int unsigned CDT_BIT_EXPIRY  = 7;  // Expiry flag in the condition flags.
    localparam int unsigned CDT_BIT_IRQ_EXP = 0;  // Expiry event in status and mask.

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0]  CDT_BYTE_RST  = 8'h00;   // Control, holding and mask bytes.
    localparam logic [15:0] CDT_COUNT_RST = 16'h0000; // Counter value after reset.
    localparam logic [31:0] CDT_WORD_RST  = 32'h0000_0000; // Read data after reset.

    ////////////////////////////////////////////////////////////////////////////////
    // Prescale counts, in core clock cycles per timer tick.
    localparam int unsigned CDT_DIV_SLOW = 16;  // Rate select low.
    localparam int unsigned CDT_DIV_FAST = 2;   // Rate select high.
    localparam logic [3:0]  CDT_TERM_SLOW = 4'(CDT_DIV_SLOW - 1); // Last prescale count.
    localparam logic [3:0]  CDT_TERM_FAST = 4'(CDT_DIV_FAST - 1); // Last prescale count.

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        CDT_APB_IDLE = 2'b01,  // Waiting for an access phase.
        CDT_APB_DONE = 2'b10   // Answer presented with pready.
    } cdt_apb_state_t;

endpackage : cdt_pkg

// ==== include/cdt_tick_if.sv ====
`timescale 1ns/100ps
// Carries the control, tick and count signals between the timer's parts.
interface cdt_tick_if;
    logic        run;         // Counting enabled.
    logic        rate;        // Rate select, high for the fast tick.
    logic        restart;     // Restart the prescaler from zero.
    logic        tick;        // One-cycle timer tick.
    logic        load;        // One-cycle load request.
    logic [15:0] load_value;  // Value taken on a load.
    logic [15:0] count;       // Current count.
    logic        zero_evt;    // One-cycle pulse when the count reaches zero.

    modport ctl (output run, rate, restart, load, load_value, input tick, count, zero_evt);
    modport pre (input run, rate, restart, output tick);
    modport cnt (input run, tick, load, load_value, output count, zero_evt);
endinterface : cdt_tick_if

// ==== verilog/cdt_prescaler.sv ====
`timescale 1ns/100ps
// Divides the core clock into the timer tick selected by the rate bit.
module cdt_prescaler
    import cdt_pkg::*;
(
    input  wire logic core_clk,  // Core clock.
    input  wire logic rstn,      // Synchronous reset, active low.
    cdt_tick_if.pre   tif        // Tick side of the timer.
);
    import cdt_pkg::*;

    // Whole state of the prescaler.
    typedef struct packed {
        logic [3:0] cnt;   // Cycles since the last tick.
        logic       tick;  // Registered tick pulse.
    } cdt_pre_state_t;

    cdt_pre_state_t s_r;    // Present state.
    cdt_pre_state_t s_nxt;  // Next state.
    logic [3:0]     term;   // Last count of the selected period.

    ////////////////////////////////////////////////////////////////////////////////
    // Counts up to the selected terminal value and pulses the tick there.
    always_comb
    begin
        s_nxt = s_r;
        term  = tif.rate ? CDT_TERM_FAST : CDT_TERM_SLOW;  // R4
        if (!tif.run || tif.restart)
        begin
            // A stopped or freshly loaded timer starts a whole period.
            s_nxt.cnt  = 4'h0;
            s_nxt.tick = 1'b0;
        end
        else if (s_r.cnt >= term)
        begin
            // Period complete: one tick.
            s_nxt.cnt  = 4'h0;
            s_nxt.tick = 1'b1;  // R4
        end
        else
        begin
            s_nxt.cnt  = s_r.cnt + 4'h1;
            s_nxt.tick = 1'b0;
        end
    end

    // Registers the state.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tif.tick = s_r.tick;  // Tick straight from a flip-flop.

endmodule : cdt_prescaler

// ==== verilog/cdt_down_counter.sv ====
`timescale 1ns/100ps
// Sixteen-bit down counter with load and a zero event.
module cdt_down_counter
    import cdt_pkg::*;
(
    input  wire logic core_clk,  // Core clock.
    input  wire logic rstn,      // Synchronous reset, active low.
    cdt_tick_if.cnt   tif        // Counter side of the timer.
);
    import cdt_pkg::*;

    // Whole state of the counter.
    typedef struct packed {
        logic [15:0] count;     // Current count.
        logic        zero_evt;  // Pulse in the cycle the count shows zero.
    } cdt_cnt_state_t;

    cdt_cnt_state_t s_r;    // Present state.
    cdt_cnt_state_t s_nxt;  // Next state.

    ////////////////////////////////////////////////////////////////////////////////
    // Load has priority over counting; a tick only counts while running.
    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.zero_evt = 1'b0;
        if (tif.load)
        begin
            s_nxt.count = tif.load_value;  // R10
        end
        else if (tif.run && tif.tick)
        begin
            // Counts on from whatever value it holds; zero wraps without an event.
            s_nxt.count    = s_r.count - 16'h0001;       // R1
            s_nxt.zero_evt = (s_r.count == 16'h0001);     // R6
        end
    end

    // Registers the state; a halted counter simply keeps its value.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            s_r.count    <= CDT_COUNT_RST;
            s_r.zero_evt <= 1'b0;
        end
        else
            s_r <= s_nxt;  // R2
    end

    assign tif.count    = s_r.count;
    assign tif.zero_evt = s_r.zero_evt;

endmodule : cdt_down_counter

// ==== verilog/cdt_timer.sv ====
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// Behaviour
// R1 - While running, count down once per tick.
// R2 - Writing run zero halts; count stays frozen.
// R3 - Load strobe loads, then clears by itself.
// R4 - Rate zero divides by sixteen, one by two.
// R5 - Software keeps rate fixed while running.
// R6 - Expiry flag sets when count reaches zero.
// R7 - Expiry clears on write one or stop.
// R8 - High byte port reads and writes bits 15-8.
// R9 - Low byte port reads and writes bits 7-0.
// R10 - Load takes written value; reset clears control.
// R11 - Byte ports read the current count.
module cdt_timer
    import cdt_pkg::*;
(
    input  wire logic        core_clk,  // Core clock, 100 MHz.
    input  wire logic        rstn,      // Synchronous reset, active low.
    input  wire logic [7:0]  paddr,     // APB byte address.
    input  wire logic        psel,      // APB select.
    input  wire logic        penable,   // APB enable.
    input  wire logic        pwrite,    // APB direction, high for write.
    input  wire logic [31:0] pwdata,    // APB write data.
    output logic      [31:0] prdata,    // APB read data.
    output logic             pready,    // APB ready.
    output logic             pslverr,   // APB error for an unmapped address.
    output logic             irq        // Level interrupt.
);
    import cdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    // Whole state of the top level.
    typedef struct packed {
        cdt_apb_state_t st;         // Bus slave state.
        logic           run;        // Run enable.
        logic           load;       // Load strobe.
        logic           rate;       // Rate select.
        logic           expiry;     // Expiry flag.
        logic [7:0]     hold_hi;    // Written upper byte.
        logic [7:0]     hold_lo;    // Written lower byte.
        logic [7:0]     irq_stat;   // Sticky interrupt status.
        logic [7:0]     irq_mask;   // Interrupt mask.
        logic [31:0]    prdata;     // Registered read data.
        logic           pready;     // Registered ready.
        logic           pslverr;    // Registered error.
        logic           irq;        // Registered interrupt.
    } cdt_top_state_t;

    cdt_top_state_t s_r;      // Present state.
    cdt_top_state_t s_nxt;    // Next state.
    logic           wr_fire;  // A write completes at this edge.
    logic           mapped;   // The address hits a register.
    logic [7:0]     rd_byte;  // Byte selected for reading.

    cdt_tick_if tif ();       // Link to the prescaler and the counter.

    ////////////////////////////////////////////////////////////////////////////////
    // Sub-blocks.

    // Tick generator.
    cdt_prescaler u_pre (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tif      (tif)
    );

    // Sixteen-bit down counter.
    cdt_down_counter u_cnt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .tif      (tif)
    );

    // Control reaches the sub-blocks straight from the registers.
    assign tif.run        = s_r.run;
    assign tif.rate       = s_r.rate;
    assign tif.load       = s_r.load;                 // R3
    assign tif.restart    = s_r.load;
    assign tif.load_value = {s_r.hold_hi, s_r.hold_lo};  // R10

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode.

    // Picks the byte shown for the addressed register.
    always_comb
    begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            CDT_OFS_CTRL:
                rd_byte = {s_r.run, s_r.load, s_r.rate, 5'h00};
            CDT_OFS_HIGH:
                rd_byte = tif.count[15:8];  // R8 R11
            CDT_OFS_LOW:
                rd_byte = tif.count[7:0];   // R9 R11
            CDT_OFS_FLAGS:
                rd_byte = {s_r.expiry, 7'h00};
            CDT_OFS_IRQ_STAT:
                rd_byte = s_r.irq_stat;
            CDT_OFS_IRQ_MASK:
                rd_byte = s_r.irq_mask;
            default:
                mapped = 1'b0;  // Unmapped: reads zero, answers with an error.
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    // Bus slave, register writes, flags and interrupt.
    always_comb
    begin
        s_nxt   = s_r;
        wr_fire = psel && penable && s_r.pready && pwrite && mapped;

        // The access phase lasts two cycles: pready rises in the second.
        case (s_r.st)
            CDT_APB_IDLE:
            begin
                if (psel && penable)
                begin
                    s_nxt.st      = CDT_APB_DONE;
                    s_nxt.pready  = 1'b1;
                    s_nxt.pslverr = !mapped;
                    s_nxt.prdata  = pwrite ? CDT_WORD_RST : {24'h000000, rd_byte};
                end
            end
            CDT_APB_DONE:
            begin
                s_nxt.st      = CDT_APB_IDLE;
                s_nxt.pready  = 1'b0;
                s_nxt.pslverr = 1'b0;
            end
            default:
            begin
                s_nxt.st     = CDT_APB_IDLE;
                s_nxt.pready = 1'b0;
            end
        endcase

        // The load strobe lasts one cycle, the cycle the counter loads.
        s_nxt.load = 1'b0;  // R3

        if (wr_fire)
        begin
            case (paddr)
                CDT_OFS_CTRL:
                begin
                    s_nxt.run  = pwdata[CDT_BIT_RUN];   // R1 R2
                    s_nxt.rate = pwdata[CDT_BIT_RATE];  // R4
                    s_nxt.load = pwdata[CDT_BIT_LOAD];  // R3
                    if (!pwdata[CDT_BIT_RUN])
                        s_nxt.expiry = 1'b0;  // R7
                end
                CDT_OFS_HIGH:
                    s_nxt.hold_hi = pwdata[7:0];  // R8
                CDT_OFS_LOW:
                    s_nxt.hold_lo = pwdata[7:0];  // R9
                CDT_OFS_FLAGS:
                begin
                    if (pwdata[CDT_BIT_EXPIRY])
                        s_nxt.expiry = 1'b0;  // R7
                end
                CDT_OFS_IRQ_STAT:
                    s_nxt.irq_stat = s_r.irq_stat & ~pwdata[7:0];
                CDT_OFS_IRQ_MASK:
                    s_nxt.irq_mask = pwdata[7:0];
                default:
                    s_nxt.irq_mask = s_r.irq_mask;  // Not reached: mapped is required.
            endcase
        end

        // Setting follows clearing, so an event in the clearing cycle is kept.
        if (tif.zero_evt)
        begin
            s_nxt.expiry                    = 1'b1;  // R6
            s_nxt.irq_stat[CDT_BIT_IRQ_EXP] = 1'b1;
        end

        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Reset clears every control bit and flag.
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            s_r.st       <= CDT_APB_IDLE;
            s_r.run      <= 1'b0;  // R10
            s_r.load     <= 1'b0;  // R10
            s_r.rate     <= 1'b0;  // R10
            s_r.expiry   <= 1'b0;  // R10
            s_r.hold_hi  <= CDT_BYTE_RST;
            s_r.hold_lo  <= CDT_BYTE_RST;
            s_r.irq_stat <= CDT_BYTE_RST;
            s_r.irq_mask <= CDT_BYTE_RST;
            s_r.prdata   <= CDT_WORD_RST;
            s_r.pready   <= 1'b0;
            s_r.pslverr  <= 1'b0;
            s_r.irq      <= 1'b0;
        end
        else
            s_r <= s_nxt;
    end

    // Every output comes from a flip-flop.
    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq     = s_r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    // A counted tick lowers the count by exactly one.
    property p_run_counts;
        @(posedge core_clk) disable iff (!rstn)
        (tif.run && tif.tick && !tif.load) |=> (tif.count == $past(tif.count) - 16'h0001);
    endproperty
    a_run_counts: assert property (p_run_counts) else $error("count did not decrement"); // R1

    // A halted counter keeps its value.
    property p_stop_freezes;
        @(posedge core_clk) disable iff (!rstn)
        (!tif.run && !tif.load) |=> $stable(tif.count);
    endproperty
    a_stop_freezes: assert property (p_stop_freezes) else $error("halted count moved"); // R2

    // The strobe is gone one cycle after it rose, and the count was loaded.
    property p_load_done;
        @(posedge core_clk) disable iff (!rstn)
        s_r.load |=> (!s_r.load || $past(wr_fire)) && (tif.count == $past(tif.load_value));
    endproperty
    a_load_done: assert property (p_load_done) else $error("load not completed"); // R3

    // The slow rate leaves at least eight quiet cycles after a tick.
    property p_rate_slow;
        @(posedge core_clk) disable iff (!rstn)
        (tif.tick && !s_r.rate && s_r.run) |=> !tif.tick [*8];
    endproperty
    a_rate_slow: assert property (p_rate_slow) else $error("slow tick too early"); // R4

    // The fast rate ticks every second cycle while undisturbed.
    property p_rate_fast;
        @(posedge core_clk) disable iff (!rstn)
        (tif.tick && s_r.rate && s_r.run && !s_r.load && !wr_fire)
            |=> !tif.tick ##1 (tif.tick || !s_r.run || $past(s_r.load) || $past(wr_fire));
    endproperty
    a_rate_fast: assert property (p_rate_fast) else $error("fast tick period wrong"); // R4

    // Reaching zero raises the flag in the next cycle.
    property p_expiry_set;
        @(posedge core_clk) disable iff (!rstn)
        tif.zero_evt |=> s_r.expiry;
    endproperty
    a_expiry_set: assert property (p_expiry_set) else $error("expiry not set"); // R6

    // Stopping the timer clears the flag unless zero arrives together.
    property p_expiry_stop;
        @(posedge core_clk) disable iff (!rstn)
        (wr_fire && paddr == CDT_OFS_CTRL && !pwdata[CDT_BIT_RUN] && !tif.zero_evt)
            |=> !s_r.expiry;
    endproperty
    a_expiry_stop: assert property (p_expiry_stop) else $error("expiry not cleared"); // R7

    // A read of the high port shows the count's upper byte.
    property p_read_high;
        @(posedge core_clk) disable iff (!rstn)
        ($rose(pready) && paddr == CDT_OFS_HIGH && !pwrite)
            |-> (prdata[7:0] == $past(tif.count[15:8]));
    endproperty
    a_read_high: assert property (p_read_high) else $error("high byte read wrong"); // R8

    // A read of the low port shows the count's lower byte.
    property p_read_low;
        @(posedge core_clk) disable iff (!rstn)
        ($rose(pready) && paddr == CDT_OFS_LOW && !pwrite)
            |-> (prdata[7:0] == $past(tif.count[7:0]));
    endproperty
    a_read_low: assert property (p_read_low) else $error("low byte read wrong"); // R9

    // Main scenarios.
    c_load: cover property (@(posedge core_clk) disable iff (!rstn) s_r.load ##1 s_r.run);
    c_expiry: cover property (@(posedge core_clk) disable iff (!rstn) $rose(s_r.expiry));
    c_irq: cover property (@(posedge core_clk) disable iff (!rstn) $rose(irq));

endmodule : cdt_timer

// ==== sim/cdt_timer_tb_top.sv ====
`timescale 1ns/100ps
// Self-checking bench for the countdown timer, driven over APB with seeded random loads.
module cdt_timer_tb_top;
    import cdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned LIMIT = 20000;  // Cycle ceiling; the tests need about 2000.
    localparam int          SPAN  = 320;    // Core cycles the timer runs in a rate test.

    logic        core_clk = 1'b0;      // Core clock, 10 ns period.
    logic        rstn     = 1'b0;      // Synchronous reset, active low.
    logic [7:0]  paddr    = 8'h00;     // APB address.
    logic        psel     = 1'b0;      // APB select.
    logic        penable  = 1'b0;      // APB enable.
    logic        pwrite   = 1'b0;      // APB direction.
    logic [31:0] pwdata   = 32'h0;     // APB write data.
    logic [31:0] prdata;               // APB read data.
    logic        pready;               // APB ready.
    logic        pslverr;              // APB error.
    logic        irq;                  // Level interrupt.
    int          n_fail    = 0;        // Mismatches seen.
    int          cmp_count = 0;        // Comparisons made.
    int unsigned cyc       = 0;        // Cycles since time zero.

    cdt_timer dut_u (
        .core_clk (core_clk),
        .rstn     (rstn),
        .paddr    (paddr),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .irq      (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock source.
    always #5 core_clk = ~core_clk;

    // Cut a hang short: a run past the ceiling counts as a mismatch.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d.", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // Compare one value and report a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer: setup, then access held until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the bench ceiling ends a wait that never sees pready.
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write one register byte; a mapped write must not report an error.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    // Read one register and compare it with the expected byte.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, {24'h0, exp});
        chk({31'h0, e}, 32'h0);
    endtask : rd

    // Read the live count through both byte ports.
    task automatic rd_count(output logic [15:0] v);
        logic [31:0] r;
        logic        e;
        apb(1'b0, CDT_OFS_HIGH, 32'h0, r, e);
        v[15:8] = r[7:0];
        apb(1'b0, CDT_OFS_LOW, 32'h0, r, e);
        v[7:0] = r[7:0];
    endtask : rd_count

    // Settle a few edges, then check the interrupt level.
    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge core_clk);
        #1;
        chk({31'h0, irq}, {31'h0, exp});
    endtask : chk_irq

    // True when the count dropped by the ticks that fit in the run time.
    function automatic logic span_ok(logic [15:0] was, logic [15:0] now, int div);
        int d;
        d = int'(16'(was - now));
        return (d >= SPAN / div - 1) && (d <= (SPAN + 10) / div + 1);
    endfunction : span_ok

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        logic [7:0]  offs [6];
        logic [31:0] r;
        logic        e;
        logic [15:0] v;
        logic [15:0] c0;
        logic [15:0] c1;
        int unsigned sd;
        int          div;
        offs = '{CDT_OFS_CTRL, CDT_OFS_HIGH, CDT_OFS_LOW, CDT_OFS_FLAGS,
                 CDT_OFS_IRQ_STAT, CDT_OFS_IRQ_MASK};
        sd = $urandom(48714);
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        // Every register comes out of reset at zero.
        foreach (offs[i])
            rd(offs[i], CDT_BYTE_RST);
        chk_irq(1'b0);
        // An unmapped address answers with an error and zero data.
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h1C, 32'hFF, r, e);
        chk({31'h0, e}, 32'h1);
        // Loads of corner and random values while stopped.
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
            wr(CDT_OFS_HIGH, v[15:8]);
            wr(CDT_OFS_LOW, v[7:0]);
            wr(CDT_OFS_CTRL, 8'h40);
            rd(CDT_OFS_CTRL, 8'h00);
            repeat (40) @(posedge core_clk);
            rd(CDT_OFS_HIGH, v[15:8]);
            rd(CDT_OFS_LOW, v[7:0]);
        end
        // Both tick rates: count, stop and freeze, then resume without a load.
        for (int rt = 0; rt < 2; rt++)
        begin
            div = (rt == 1) ? int'(CDT_DIV_FAST) : int'(CDT_DIV_SLOW);
            wr(CDT_OFS_HIGH, 8'h10);
            wr(CDT_OFS_LOW, 8'h00);
            wr(CDT_OFS_CTRL, (rt == 1) ? 8'hE0 : 8'hC0);
            repeat (SPAN) @(posedge core_clk);
            wr(CDT_OFS_CTRL, (rt == 1) ? 8'h20 : 8'h00);
            rd(CDT_OFS_CTRL, (rt == 1) ? 8'h20 : 8'h00);
            rd_count(c0);
            chk({31'h0, span_ok(16'h1000, c0, div)}, 32'h1);
            repeat (50) @(posedge core_clk);
            rd_count(c1);
            chk({16'h0, c1}, {16'h0, c0});
            wr(CDT_OFS_CTRL, (rt == 1) ? 8'hA0 : 8'h80);
            repeat (SPAN) @(posedge core_clk);
            wr(CDT_OFS_CTRL, (rt == 1) ? 8'h20 : 8'h00);
            rd_count(c1);
            chk({31'h0, span_ok(c0, c1, div)}, 32'h1);
        end
        // Expiry with the interrupt unmasked, then cleared by writing ones.
        wr(CDT_OFS_IRQ_MASK, 8'h01);
        wr(CDT_OFS_HIGH, 8'h00);
        wr(CDT_OFS_LOW, 8'h03);
        wr(CDT_OFS_CTRL, 8'hE0);
        repeat (30) @(posedge core_clk);
        rd(CDT_OFS_FLAGS, 8'h80);
        rd(CDT_OFS_IRQ_STAT, 8'h01);
        chk_irq(1'b1);
        wr(CDT_OFS_FLAGS, 8'h80);
        rd(CDT_OFS_FLAGS, 8'h00);
        chk_irq(1'b1);
        wr(CDT_OFS_IRQ_STAT, 8'h01);
        chk_irq(1'b0);
        // Expiry with the interrupt masked, then cleared by stopping.
        wr(CDT_OFS_IRQ_MASK, 8'h00);
        wr(CDT_OFS_CTRL, 8'hE0);
        repeat (30) @(posedge core_clk);
        rd(CDT_OFS_FLAGS, 8'h80);
        rd(CDT_OFS_IRQ_STAT, 8'h01);
        chk_irq(1'b0);
        wr(CDT_OFS_CTRL, 8'h20);
        rd(CDT_OFS_FLAGS, 8'h00);
        wr(CDT_OFS_IRQ_STAT, 8'h01);
        rd(CDT_OFS_IRQ_STAT, 8'h00);
        tally_and_finish();
    end

endmodule : cdt_timer_tb_top
